// >>> inc/cnc_pkg.sv
package cnc_pkg;

    // ****************************************
    // Register indices; byte address is four times the index.
    // ****************************************
    localparam logic [9:0] IDX_PAGE = 10'h008;
    localparam logic [9:0] IDX_CTRL = 10'h130;
    localparam logic [9:0] IDX_FTW0 = 10'h132;
    localparam logic [9:0] IDX_FTW1 = 10'h133;
    localparam logic [9:0] IDX_FTW2 = 10'h134;
    localparam logic [9:0] IDX_FTW3 = 10'h135;
    localparam logic [9:0] IDX_FTW5 = 10'h136;
    localparam logic [9:0] IDX_PHS0 = 10'h137;
    localparam logic [9:0] IDX_PHS1 = 10'h138;
    localparam logic [9:0] IDX_MOD0 = 10'h13a;
    localparam logic [9:0] IDX_MOD1 = 10'h13b;
    localparam logic [9:0] IDX_MOD3 = 10'h13c;
    localparam logic [9:0] IDX_MOD4 = 10'h13d;
    localparam logic [9:0] IDX_MOD5 = 10'h13f;
    localparam logic [9:0] IDX_DLT0 = 10'h140;
    localparam logic [9:0] IDX_DLT1 = 10'h141;
    localparam logic [9:0] IDX_DLT2 = 10'h142;
    localparam logic [9:0] IDX_DLT3 = 10'h143;
    localparam logic [9:0] IDX_DLT4 = 10'h144;
    localparam logic [9:0] IDX_DLT5 = 10'h145;
    localparam logic [9:0] IDX_UPDATE = 10'h148;
    localparam logic [9:0] IDX_STATUS = 10'h149;
    localparam logic [9:0] IDX_INTERP = 10'h14a;
    localparam logic [9:0] IDX_FTW4 = 10'h14b;
    localparam logic [9:0] IDX_MOD2 = 10'h14c;

    // ****************************************
    // Control fields and layout of the staging word.
    // ****************************************
    localparam int CTRL_SIDEBAND = 1;
    localparam int CTRL_MODULUS = 2;
    localparam int CTRL_ENABLE = 6;
    localparam int PAGE_STRIDE = 3;
    localparam int PAGE_W = 6;
    localparam int SH_FTW = 0;
    localparam int SH_MOD = 48;
    localparam int SH_DLT = 96;
    localparam int SH_PHS = 144;
    localparam int SH_W = 160;
    localparam int INTERP_W = 4;
    localparam logic [3:0] INTERP_RST = 4'h1;
    localparam logic [5:0] PAGE_RST = 6'h00;

    // ****************************************
    // Bus transfer codes.
    // ****************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// >>> hdl/cnc_osc_core.sv
`timescale 1ns/1ps
module cnc_osc_core #(
    parameter int AW = 48,
    parameter int PW = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic tick_in,
    input wire logic en_in,
    input wire logic mod_en_in,
    input wire logic flip_in,
    input wire logic [AW-1:0] ftw_in,
    input wire logic [AW-1:0] mod_in,
    input wire logic [AW-1:0] delta_in,
    input wire logic [PW-1:0] poff_in,
    output logic [PW-1:0] phase_out,
    output logic valid_out
);

    typedef struct packed {
        logic [AW-1:0] acc;
        logic [AW-1:0] rem;
        logic [PW-1:0] phase;
        logic valid;
    } cnc_core_t;

    cnc_core_t s_q;
    cnc_core_t s_d;

    // ****************************************
    // Phase accumulator with optional fractional modulus.
    // ****************************************
    always_comb begin
        logic [AW:0] sum;
        logic carry;
        logic [PW-1:0] pw;
        sum = {1'b0, s_q.rem} + {1'b0, delta_in};
        carry = mod_en_in && (mod_in != '0) && (sum >= {1'b0, mod_in});
        pw = s_q.acc[AW-1 -: PW] + poff_in;
        s_d = s_q;
        s_d.valid = 1'b0;
        if (!en_in) begin
            s_d.acc = '0;
            s_d.rem = '0;
            s_d.phase = '0;
        end else if (tick_in) begin
            s_d.acc = s_q.acc + ftw_in + AW'(carry);
            if (carry) begin
                s_d.rem = AW'(sum - {1'b0, mod_in});
            end else if (mod_en_in) begin
                s_d.rem = AW'(sum);
            end else begin
                s_d.rem = '0;
            end
            s_d.phase = flip_in ? PW'(~pw + 1'b1) : pw;
            s_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign phase_out = s_q.phase;
    assign valid_out = s_q.valid;

endmodule

// >>> hdl/cnc_channel_nco.sv
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - A per-channel sideband bit passes the phase as is at 0 and negates it at 1 for a flip.
// - In integer mode the accumulator grows by the 48-bit tuning word each channel tick.
// - The oscillator steps once per channel tick, the data strobe divided by the interp factor.
// - A 16-bit phase shift is added at the top of the accumulator, full circle being 2^16.
// - In modulus mode the remainder gains the numerator and carries one LSB at the denominator.
// - The page mask picks the channels taking writes, bit 0 for channel 0 and bit 3 for 1.
// - Control bit 6 turns the paged channels' oscillators on at 1 and off at 0.
// - Control bit 2 selects modulus mode at 1 and integer mode at 0 for paged channels.
module cnc_channel_nco #(
    parameter int NCH = 2,
    parameter int AW = 48,
    parameter int PW = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire logic DATA_STROBE_IN,
    output logic [NCH*PW-1:0] CH_PHASE_OUT,
    output logic [NCH-1:0] CH_VALID_OUT
);

    localparam int SW = cnc_pkg::SH_W;
    localparam int IW = cnc_pkg::INTERP_W;

    typedef struct packed {
        logic [9:0] idx;
        logic wr;
        logic [cnc_pkg::PAGE_W-1:0] page;
        logic [NCH-1:0] en;
        logic [NCH-1:0] mm;
        logic [NCH-1:0] sb;
        logic [SW-1:0] shadow;
        logic [NCH*SW-1:0] act;
        logic [IW-1:0] interp;
        logic [IW-1:0] cnt;
        logic tick;
        logic [31:0] rdata;
        logic ready;
        logic resp;
    } cnc_top_t;

    cnc_top_t s_q;
    cnc_top_t s_d;

    // ****************************************
    // Byte position of each value byte in the staging word.
    // ****************************************
    function automatic logic [8:0] byte_pos(input logic [9:0] idx);
        logic [8:0] r;
        r = '0;
        case (idx)
            cnc_pkg::IDX_FTW0: r = {1'b1, 8'(cnc_pkg::SH_FTW + 0)};
            cnc_pkg::IDX_FTW1: r = {1'b1, 8'(cnc_pkg::SH_FTW + 8)};
            cnc_pkg::IDX_FTW2: r = {1'b1, 8'(cnc_pkg::SH_FTW + 16)};
            cnc_pkg::IDX_FTW3: r = {1'b1, 8'(cnc_pkg::SH_FTW + 24)};
            cnc_pkg::IDX_FTW4: r = {1'b1, 8'(cnc_pkg::SH_FTW + 32)};
            cnc_pkg::IDX_FTW5: r = {1'b1, 8'(cnc_pkg::SH_FTW + 40)};
            cnc_pkg::IDX_PHS0: r = {1'b1, 8'(cnc_pkg::SH_PHS + 0)};
            cnc_pkg::IDX_PHS1: r = {1'b1, 8'(cnc_pkg::SH_PHS + 8)};
            cnc_pkg::IDX_MOD0: r = {1'b1, 8'(cnc_pkg::SH_MOD + 0)};
            cnc_pkg::IDX_MOD1: r = {1'b1, 8'(cnc_pkg::SH_MOD + 8)};
            cnc_pkg::IDX_MOD2: r = {1'b1, 8'(cnc_pkg::SH_MOD + 16)};
            cnc_pkg::IDX_MOD3: r = {1'b1, 8'(cnc_pkg::SH_MOD + 24)};
            cnc_pkg::IDX_MOD4: r = {1'b1, 8'(cnc_pkg::SH_MOD + 32)};
            cnc_pkg::IDX_MOD5: r = {1'b1, 8'(cnc_pkg::SH_MOD + 40)};
            cnc_pkg::IDX_DLT0: r = {1'b1, 8'(cnc_pkg::SH_DLT + 0)};
            cnc_pkg::IDX_DLT1: r = {1'b1, 8'(cnc_pkg::SH_DLT + 8)};
            cnc_pkg::IDX_DLT2: r = {1'b1, 8'(cnc_pkg::SH_DLT + 16)};
            cnc_pkg::IDX_DLT3: r = {1'b1, 8'(cnc_pkg::SH_DLT + 24)};
            cnc_pkg::IDX_DLT4: r = {1'b1, 8'(cnc_pkg::SH_DLT + 32)};
            cnc_pkg::IDX_DLT5: r = {1'b1, 8'(cnc_pkg::SH_DLT + 40)};
            default: r = '0;
        endcase
        return r;
    endfunction

    // ****************************************
    // Bus slave, register file and channel tick.
    // ****************************************
    always_comb begin
        logic take;
        logic [8:0] bp;
        logic [IW-1:0] last;
        logic [31:0] rd;
        logic [9:0] aidx;
        take = HSEL_IN && HREADY_IN && (HTRANS_IN == cnc_pkg::HTRANS_NONSEQ);
        aidx = HADDR_IN[11:2];
        bp = byte_pos(s_q.idx);
        last = (s_q.interp == '0) ? '0 : IW'(s_q.interp - 1'b1);
        rd = '0;
        s_d = s_q;
        s_d.ready = 1'b1;
        s_d.resp = 1'b0;

        // Address phase: latch a write, or prepare read data.
        s_d.wr = 1'b0;
        if (take) begin
            s_d.idx = aidx;
            s_d.wr = HWRITE_IN && (HADDR_IN[31:12] == '0);
            if (!HWRITE_IN && (HADDR_IN[31:12] == '0)) begin
                case (aidx)
                    cnc_pkg::IDX_PAGE: rd = 32'(s_q.page);
                    cnc_pkg::IDX_INTERP: rd = 32'(s_q.interp);
                    cnc_pkg::IDX_STATUS: begin
                        rd[NCH-1:0] = s_q.en;
                        rd[8 +: NCH] = s_q.mm;
                        rd[16 +: NCH] = s_q.sb;
                    end
                    default: rd = '0;
                endcase
            end
            if (!HWRITE_IN) begin
                s_d.rdata = rd;
            end
        end

        // Data phase: store the written byte.
        if (s_q.wr) begin
            if (bp[8]) begin
                s_d.shadow[bp[7:0] +: 8] = HWDATA_IN[7:0];
            end
            case (s_q.idx)
                cnc_pkg::IDX_PAGE: begin
                    s_d.page = HWDATA_IN[cnc_pkg::PAGE_W-1:0];
                end
                cnc_pkg::IDX_INTERP: begin
                    s_d.interp = HWDATA_IN[IW-1:0];
                end
                default: begin
                end
            endcase
            for (int c = 0; c < NCH; c++) begin
                if (s_q.page[c*cnc_pkg::PAGE_STRIDE]) begin
                    if (s_q.idx == cnc_pkg::IDX_CTRL) begin
                        s_d.en[c] = HWDATA_IN[cnc_pkg::CTRL_ENABLE];
                        s_d.mm[c] = HWDATA_IN[cnc_pkg::CTRL_MODULUS];
                        s_d.sb[c] = HWDATA_IN[cnc_pkg::CTRL_SIDEBAND];
                    end
                    if (s_q.idx == cnc_pkg::IDX_UPDATE && HWDATA_IN[0]) begin
                        s_d.act[c*SW +: SW] = s_q.shadow;
                    end
                end
            end
        end

        // Channel tick: one per interp-factor data strobes.
        s_d.tick = 1'b0;
        if (DATA_STROBE_IN) begin
            if (s_q.cnt >= last) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = IW'(s_q.cnt + 1'b1);
            end
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RESET_IN) begin
            s_q <= '0;
            s_q.page <= cnc_pkg::PAGE_RST;
            s_q.interp <= cnc_pkg::INTERP_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA_OUT = s_q.rdata;
    assign HREADYOUT_OUT = s_q.ready;
    assign HRESP_OUT = s_q.resp;

    // ****************************************
    // One oscillator per channel.
    // ****************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        cnc_osc_core #(
            .AW(AW),
            .PW(PW)
        ) u_core (
            .clk_in(SYS_CLK_IN),
            .rst_in(RESET_IN),
            .tick_in(s_q.tick),
            .en_in(s_q.en[c]),
            .mod_en_in(s_q.mm[c]),
            .flip_in(s_q.sb[c]),
            .ftw_in(s_q.act[c*SW + cnc_pkg::SH_FTW +: AW]),
            .mod_in(s_q.act[c*SW + cnc_pkg::SH_MOD +: AW]),
            .delta_in(s_q.act[c*SW + cnc_pkg::SH_DLT +: AW]),
            .poff_in(s_q.act[c*SW + cnc_pkg::SH_PHS +: PW]),
            .phase_out(CH_PHASE_OUT[c*PW +: PW]),
            .valid_out(CH_VALID_OUT[c])
        );
    end

endmodule

// >>> testbench/cnc_checker.sv
`timescale 1ns/1ps
// ****************************************
// Bus and oscillator properties at the top ports.
// ****************************************
module cnc_checker #(
    parameter int NCH = 2,
    parameter int PW = 16
) (
    input wire logic SYS_CLK_IN,
    input wire logic RESET_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic HREADY_IN,
    input wire logic [31:0] HRDATA_OUT,
    input wire logic HREADYOUT_OUT,
    input wire logic HRESP_OUT,
    input wire logic DATA_STROBE_IN,
    input wire logic [NCH*PW-1:0] CH_PHASE_OUT,
    input wire logic [NCH-1:0] CH_VALID_OUT
);
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RESET_IN);
    wire logic rd_take = HSEL_IN && HREADY_IN && !HWRITE_IN
        && HTRANS_IN == cnc_pkg::HTRANS_NONSEQ;
    a_resp_okay: assert property (HRESP_OUT == 1'b0)
        else $error("bus response not okay");
    a_ready_after: assert property (!RESET_IN |=> HREADYOUT_OUT)
        else $error("bus not ready after reset");
    a_valid_cause: assert property (CH_VALID_OUT != 0 |-> $past(DATA_STROBE_IN, 2))
        else $error("phase valid without strobe");
    a_valid_idle: assert property (!DATA_STROBE_IN [*3] |=> CH_VALID_OUT == 0)
        else $error("phase valid while strobe idle");
    a_phase_hold0: assert property (!$stable(CH_PHASE_OUT[PW-1:0])
        |-> CH_VALID_OUT[0] || CH_PHASE_OUT[PW-1:0] == 0)
        else $error("channel 0 phase moved without tick");
    a_phase_hold1: assert property ($changed(CH_PHASE_OUT[2*PW-1:PW])
        |-> CH_VALID_OUT[1] || CH_PHASE_OUT[2*PW-1:PW] == 0)
        else $error("channel 1 phase moved without tick");
    a_wo_reads_zero: assert property (rd_take && HADDR_IN[11:2] == cnc_pkg::IDX_FTW0
        && HADDR_IN[31:12] == 0 |=> HRDATA_OUT == 32'h0000_0000)
        else $error("write-only register read nonzero");
    a_unmapped_zero: assert property (rd_take && HADDR_IN[31:12] != 0
        |=> HRDATA_OUT == 32'h0000_0000)
        else $error("unmapped read nonzero");
    a_rdata_stands: assert property (!$past(rd_take) |-> $stable(HRDATA_OUT))
        else $error("read data changed without read");
    c_valid_ch0: cover property (CH_VALID_OUT[0]);
    c_valid_ch1: cover property (CH_VALID_OUT[1]);
    c_read: cover property (rd_take ##1 HRDATA_OUT != 0);
endmodule
bind cnc_channel_nco cnc_checker #(.NCH(NCH), .PW(PW)) u_chk (
    .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
    .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
    .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
    .DATA_STROBE_IN(DATA_STROBE_IN), .CH_PHASE_OUT(CH_PHASE_OUT), .CH_VALID_OUT(CH_VALID_OUT));

// >>> testbench/cnc_channel_nco_test.sv
`timescale 1ns/1ps
module cnc_channel_nco_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic strobe = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] phase;
    logic [1:0] valid;
    logic hready;
    logic hresp;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    cnc_channel_nco u_dut (.SYS_CLK_IN(clk), .RESET_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .DATA_STROBE_IN(strobe), .CH_PHASE_OUT(phase), .CH_VALID_OUT(valid));
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            miscompares = miscompares + 1;
            final_report();
        end
    end
    task automatic final_report();
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_phase(input logic [31:0] got, input logic [31:0] exp);
        chk_word(got, exp);
    endtask
    task automatic wait_ready();
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= cnc_pkg::HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
    endtask
    function automatic logic [31:0] ad(input logic [9:0] idx);
        return {20'h0_0000, idx, 2'h0};
    endfunction
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, ad(idx), {24'h00_0000, d}, x);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0000_0000, x);
        chk_word(x, exp);
    endtask
    task automatic tick(input int n, input logic [1:0] ev, input logic [31:0] exp);
        strobe <= 1'b1;
        repeat (n) @(posedge clk);
        strobe <= 1'b0;
        repeat (8) begin
            @(negedge clk);
            if (valid !== 2'b00) break;
        end
        chk_word({30'h0000_0000, valid}, {30'h0000_0000, ev});
        chk_phase(phase, exp);
        @(posedge clk);
    endtask
    initial begin
        logic [15:0] k;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(ad(cnc_pkg::IDX_PAGE), 32'h0000_0000);
        wr(cnc_pkg::IDX_PAGE, 8'hff);
        rd(ad(cnc_pkg::IDX_PAGE), 32'h0000_003f);
        wr(cnc_pkg::IDX_FTW0, 8'h5a);
        rd(ad(cnc_pkg::IDX_FTW0), 32'h0000_0000);
        rd(32'h0000_1000 | ad(cnc_pkg::IDX_PAGE), 32'h0000_0000);
        wr(cnc_pkg::IDX_PAGE, 8'h01);
        wr(cnc_pkg::IDX_FTW4, 8'h01);
        wr(cnc_pkg::IDX_PHS1, 8'h01);
        wr(cnc_pkg::IDX_UPDATE, 8'h01);
        wr(cnc_pkg::IDX_CTRL, 8'h40);
        rd(ad(cnc_pkg::IDX_STATUS), 32'h0000_0001);
        for (k = 0; k < 3; k++) tick(1, 2'b01, {16'h0000, 16'h0100 + k});
        wr(cnc_pkg::IDX_PAGE, 8'h08);
        wr(cnc_pkg::IDX_UPDATE, 8'h01);
        wr(cnc_pkg::IDX_CTRL, 8'h42);
        rd(ad(cnc_pkg::IDX_STATUS), 32'h0002_0003);
        for (k = 0; k < 2; k++) tick(1, 2'b11, {16'hff00 - k, 16'h0103 + k});
        wr(cnc_pkg::IDX_INTERP, 8'h02);
        tick(2, 2'b11, {16'hfefe, 16'h0105});
        wr(cnc_pkg::IDX_INTERP, 8'h01);
        wr(cnc_pkg::IDX_PAGE, 8'h01);
        wr(cnc_pkg::IDX_CTRL, 8'h00);
        repeat (2) @(posedge clk);
        chk_phase({16'h0000, phase[15:0]}, 32'h0000_0000);
        wr(cnc_pkg::IDX_FTW0, 8'hff);
        wr(cnc_pkg::IDX_FTW1, 8'hff);
        wr(cnc_pkg::IDX_FTW2, 8'hff);
        wr(cnc_pkg::IDX_FTW3, 8'hff);
        wr(cnc_pkg::IDX_FTW4, 8'h00);
        wr(cnc_pkg::IDX_PHS1, 8'h00);
        wr(cnc_pkg::IDX_MOD0, 8'h01);
        wr(cnc_pkg::IDX_DLT0, 8'h01);
        wr(cnc_pkg::IDX_UPDATE, 8'h01);
        wr(cnc_pkg::IDX_CTRL, 8'h44);
        rd(ad(cnc_pkg::IDX_STATUS), 32'h0002_0103);
        for (k = 0; k < 3; k++) tick(1, 2'b11, {16'hfefd - k, k});
        final_report();
    end
endmodule
